// file: tcc_pkg.sv
/*
  constants, register map and types of the capture/compare timer.
  assumes a single 100 MHz aclk and an axi4-lite master on the cpu side.
*/
// Summary of operation
// - pulse output a changes once only per pulse period, repeats ignored.
// - width compare written at or below count before match gives full duty.
// - period compare lowered below count lets counter run to full and wrap.
// - period rewrite after width match keeps output inactive until wrap to zero.
// - period rewrite before width match keeps output active until that match.
// - clearing the run bit drives the active level on the pulse pins.
// - disabled pin drives inverse of its level bit, the active level.
// - free-running counter plus software step gives match every step counts.
// - clear-on-match gives a match every compare plus one count clocks.
// - capture pin phases under three system clocks are ignored.
// - every edge of capture pin copies counter into capture register while running in timer mode.
// - 8-bit pwm duty set by compare value from 1/256 to 255/256.
// - event mode counts rising edges of the synchronised event pin only.
// - event count reads one less than pulses, first edge leaves zero.
// - pulse period is period compare plus one, width is width compare.
// - 8-bit pwm period is 256 count clocks, width equals compare.
// - matches are seen only when the counter steps, never on writes.
package tcc_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam int TCC_AW = 8;
  localparam logic [7:0] TCC_CTRL_OFF = 8'h00;
  localparam logic [7:0] TCC_OCTL_OFF = 8'h04;
  localparam logic [7:0] TCC_WCMP_OFF = 8'h08;
  localparam logic [7:0] TCC_PCMP_OFF = 8'h0C;
  localparam logic [7:0] TCC_CAP_OFF = 8'h10;
  localparam logic [7:0] TCC_CNT_OFF = 8'h14;
  localparam logic [7:0] TCC_STAT_OFF = 8'h18;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_RUN_B = 0;
  localparam int CTRL_MODE_B = 1;
  localparam int CTRL_BW_B = 2;
  localparam int CTRL_CLRP_B = 3;
  localparam int CTRL_CLRC_B = 4;
  localparam int CTRL_PS_LO = 8;
  localparam int OCTL_EN_B = 0;
  localparam int OCTL_ALV_B = 1;
  localparam int OCTL_STRIDE = 2;
  localparam int STAT_MA_B = 0;
  localparam int STAT_CAP_B = 2;
  localparam int STAT_OVF_B = 3;
  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [3:0] OCTL_RST = 4'h0;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CNT8_MAX = 16'h00FF;
  localparam logic [15:0] CNT16_MAX = 16'hFFFF;
  localparam logic [3:0] PS_SEL_MAX = 4'h8;
  localparam int PS_SHIFT_MIN = 3;
  localparam logic [1:0] FILT_LAST = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    TCC_WR_IDLE = 1'b0,
    TCC_WR_RESP = 1'b1
  } tcc_wr_st_t;
endpackage

// file: tcc_edge_if.sv
/*
  edge events of one conditioned pin, from filter to timer core.
  assumes both ends run on aclk.
*/
`timescale 1ns/1ps
interface tcc_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport snk (input rise, input fall);
endinterface

// file: tcc_pin_filter.sv
/*
  pin conditioner: two-flop synchroniser, three-clock glitch filter and
  edge pulses. assumes an asynchronous pin and aclk.
*/
`timescale 1ns/1ps
module tcc_pin_filter
  import tcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  tcc_edge_if.src edge_o
);
  logic sync1_r;
  logic sync2_r;
  logic lvl_r;
  logic [1:0] stab_r;
  logic rise_r;
  logic fall_r;
  logic accept;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // new level taken only after three equal samples in a row
  assign accept = (sync2_r != lvl_r) && (stab_r == FILT_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r <= 1'b0;
      stab_r <= 2'h0;
    end else if (sync2_r == lvl_r) begin
      stab_r <= 2'h0;
    end else if (accept) begin
      lvl_r <= sync2_r;
      stab_r <= 2'h0;
    end else begin
      stab_r <= stab_r + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      rise_r <= accept && sync2_r;
      fall_r <= accept && !sync2_r;
    end
  end

  assign edge_o.rise = rise_r;
  assign edge_o.fall = fall_r;
endmodule

// file: tcc_top.sv
/*
  16-bit up-counting timer with two compares, one capture register,
  two pulse pins, prescaler and event counting; axi4-lite slave.
  assumes an axi4-lite master on aclk and asynchronous timer pins.
*/
`timescale 1ns/1ps
module tcc_top
  import tcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tcc_pkg::TCC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcc_pkg::TCC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic width_capture_pin,
  input wire logic event_count_pin,
  output logic pulse_out_a,
  output logic pulse_out_b
);
  import tcc_pkg::*;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // all-ones mask of the divider bits for divisor 2^(sel+3), sel above 8 taken as 8
  function automatic logic [10:0] ps_mask(input logic [3:0] sel);
    logic [3:0] s;
    logic [11:0] m;
    s = (sel > PS_SEL_MAX) ? PS_SEL_MAX : sel;
    m = (12'h001 << (s + 4'(PS_SHIFT_MIN))) - 12'h001;
    return m[10:0];
  endfunction

  // ------------------------------------------------------------
  // registers and nets
  // ------------------------------------------------------------
  tcc_wr_st_t wst_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_map;
  logic [31:0] rd_val;
  logic rd_map;

  logic [11:0] ctrl_r;
  logic [3:0] octl_r;
  logic [15:0] cmp_r [2];
  logic [15:0] cap_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [3:0] stat_r;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic [10:0] div_r;
  logic first_r;

  logic run;
  logic evt_mode;
  logic [15:0] cnt_max;
  logic tick;
  logic cnt_en;
  logic cap_edge;
  logic cclr;
  logic wrap;
  logic pclr;
  logic step;
  logic [15:0] stepped;
  logic zero_s;
  logic [1:0] match;
  logic [1:0] wr_cmp;
  logic [1:0] act_r;
  logic [1:0] arm_r;
  logic [1:0] pin_r;

  tcc_edge_if cap_if ();
  tcc_edge_if evt_if ();

  // ------------------------------------------------------------
  // pin conditioning
  // ------------------------------------------------------------
  tcc_pin_filter u_cap_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(width_capture_pin),
    .edge_o(cap_if.src)
  );

  tcc_pin_filter u_evt_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(event_count_pin),
    .edge_o(evt_if.src)
  );

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_hold_r && (wst_r == TCC_WR_IDLE);
  assign s_axi_wready = !w_hold_r && (wst_r == TCC_WR_IDLE);
  assign s_axi_bvalid = (wst_r == TCC_WR_RESP);
  assign s_axi_bresp = bresp_r;
  assign wr_fire = aw_hold_r && w_hold_r && (wst_r == TCC_WR_IDLE);

  always_comb begin
    case (aw_addr_r)
      TCC_CTRL_OFF, TCC_OCTL_OFF, TCC_WCMP_OFF, TCC_PCMP_OFF,
      TCC_CAP_OFF, TCC_CNT_OFF, TCC_STAT_OFF: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= TCC_WR_IDLE;
      bresp_r <= RESP_OKAY;
    end else begin
      case (wst_r)
        TCC_WR_IDLE: begin
          if (wr_fire) begin
            wst_r <= TCC_WR_RESP;
            bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
          end
        end
        TCC_WR_RESP: begin
          if (s_axi_bready) begin
            wst_r <= TCC_WR_IDLE;
          end
        end
        default: wst_r <= TCC_WR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  assign wr_cmp[0] = wr_fire && (aw_addr_r == TCC_WCMP_OFF);
  assign wr_cmp[1] = wr_fire && (aw_addr_r == TCC_PCMP_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_fire && (aw_addr_r == TCC_CTRL_OFF)) begin
      ctrl_r <= 12'(merge16({4'h0, ctrl_r}, w_data_r, w_strb_r) & 16'h0F1F);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      octl_r <= OCTL_RST;
    end else if (wr_fire && (aw_addr_r == TCC_OCTL_OFF) && w_strb_r[0]) begin
      octl_r <= w_data_r[3:0];
    end
  end

  // ------------------------------------------------------------
  // status flags: a new event wins over a clear in the same cycle
  // ------------------------------------------------------------
  assign stat_clr = (wr_fire && (aw_addr_r == TCC_STAT_OFF) && w_strb_r[0])
                  ? w_data_r[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 4'h0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    rd_map = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      TCC_CTRL_OFF: rd_val = {20'h0_0000, ctrl_r};
      TCC_OCTL_OFF: rd_val = {28'h000_0000, octl_r};
      TCC_WCMP_OFF: rd_val = {16'h0000, cmp_r[0]};
      TCC_PCMP_OFF: rd_val = {16'h0000, cmp_r[1]};
      TCC_CAP_OFF: rd_val = {16'h0000, cap_r};
      TCC_CNT_OFF: rd_val = {16'h0000, cnt_r};
      TCC_STAT_OFF: rd_val = {28'h000_0000, stat_r};
      default: begin
        rd_val = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // prescaler and count enable
  // ------------------------------------------------------------
  assign run = ctrl_r[CTRL_RUN_B];
  assign evt_mode = ctrl_r[CTRL_MODE_B];
  assign cnt_max = ctrl_r[CTRL_BW_B] ? CNT16_MAX : CNT8_MAX;
  // first tick after one whole divisor, so start may lag by a count clock
  assign tick = (div_r & ps_mask(ctrl_r[CTRL_PS_LO +: 4])) ==
                ps_mask(ctrl_r[CTRL_PS_LO +: 4]);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_r <= 11'h000;
    end else begin
      div_r <= div_r + 11'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      first_r <= 1'b0;
    end else if (evt_mode && evt_if.rise) begin
      first_r <= 1'b1;
    end
  end

  // first event edge only arms the counter, which stays at zero
  assign cnt_en = evt_mode ? (evt_if.rise && first_r) : tick;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  assign cap_edge = run && !evt_mode && (cap_if.rise || cap_if.fall);
  assign cclr = cap_edge && ctrl_r[CTRL_CLRC_B];
  // equality only: a period below the count runs on to full and wraps
  assign wrap = (cnt_r == cnt_max);
  assign pclr = ctrl_r[CTRL_CLRP_B] && (cnt_r == cmp_r[1]);
  assign step = run && cnt_en && !cclr;
  assign stepped = (wrap || pclr) ? 16'h0000 : (cnt_r + 16'h0001);
  assign zero_s = step && (wrap || pclr);

  always_comb begin
    if (!run) begin
      cnt_nxt = 16'h0000;
    end else if (cclr) begin
      cnt_nxt = 16'h0000;
    end else if (step) begin
      cnt_nxt = stepped;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // capture holds until the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_r <= 16'h0000;
    end else if (cap_edge) begin
      cap_r <= cnt_r;
    end
  end

  assign stat_set[STAT_CAP_B] = cap_edge;
  assign stat_set[STAT_OVF_B] = step && wrap;

  // ------------------------------------------------------------
  // compare channels and pulse pins
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_r[ch] <= CMP_RST;
        end else if (wr_cmp[ch]) begin
          cmp_r[ch] <= merge16(cmp_r[ch], w_data_r, w_strb_r);
        end
      end

      // only a step compares, and never while this compare is written
      assign match[ch] = step && (stepped == cmp_r[ch]) && !wr_cmp[ch];
      assign stat_set[STAT_MA_B + ch] = match[ch];

      always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
          act_r[ch] <= 1'b1;
          arm_r[ch] <= 1'b1;
        end else if (zero_s && !match[ch]) begin
          act_r[ch] <= 1'b1;
          arm_r[ch] <= 1'b1;
        end else if (match[ch] && arm_r[ch]) begin
          act_r[ch] <= 1'b0;
          arm_r[ch] <= 1'b0;
        end
      end
      // a missed match leaves the pin active all period

      // level bit holds the idle level; active is its inverse
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_r[ch] <= 1'b1;
        end else if (!octl_r[OCTL_STRIDE * ch + OCTL_EN_B]) begin
          pin_r[ch] <= !octl_r[OCTL_STRIDE * ch + OCTL_ALV_B];
        end else begin
          pin_r[ch] <= act_r[ch] ^ octl_r[OCTL_STRIDE * ch + OCTL_ALV_B];
        end
      end
    end
  endgenerate

  assign pulse_out_a = pin_r[0];
  assign pulse_out_b = pin_r[1];
endmodule

// file: tcc_chk.sv
/*
  bus handshake and pin assertions for the capture/compare timer.
  assumes a bind onto the top module ports, single aclk domain.
*/
`timescale 1ns/1ps
module tcc_chk
  import tcc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcc_pkg::TCC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h06
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
  a_rd_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] <= 6'h06
    |=> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  a_pin_reset: assert property ($rose(aresetn) |-> pulse_out_a && pulse_out_b)
    else $error("pins not at disabled level after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pulse: cover property ($fell(pulse_out_a));
endmodule

// file: tcc_pin_src.sv
/*
  external pulse source for the capture and event pins.
  assumes callers run in aclk-synchronous code.
*/
`timescale 1ns/1ps
module tcc_pin_src (
  input wire logic aclk,
  output logic cap_pin,
  output logic evt_pin
);
  initial begin
    cap_pin = 1'b0;
    evt_pin = 1'b0;
  end
  // level moves just after an edge, never at the sampling instant
  task automatic cap_set(input logic v);
    @(posedge aclk);
    cap_pin <= v;
  endtask
  // one clean pulse; only its rising edge should count
  task automatic evt_pulse(input int hi, input int lo);
    @(posedge aclk);
    evt_pin <= 1'b1;
    repeat (hi) @(posedge aclk);
    evt_pin <= 1'b0;
    repeat (lo - 1) @(posedge aclk);
  endtask
endmodule

// file: tb.sv
/*
  self-checking bench for the capture/compare timer.
  assumes divisor select 0 (8 aclks per count) unless stated.
*/
`timescale 1ns/1ps
module tb
  import tcc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pulse_out_a, pulse_out_b, width_capture_pin, event_count_pin;
  int error_cnt = 0, compares = 0, cyc = 0;
  tcc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .width_capture_pin, .event_count_pin, .pulse_out_a, .pulse_out_b);
  tcc_pin_src src (.aclk, .cap_pin(width_capture_pin), .evt_pin(event_count_pin));
  always #5 aclk = ~aclk;
  // whole run is about 30k cycles; ceiling leaves margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", r, s_axi_rresp);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, RESP_OKAY, v);
    chk(n, e, v);
  endtask
  // waits for a pin level, returns the cycle stamp
  task automatic wp(input bit b, input logic v, output int t);
    while ((b ? pulse_out_b : pulse_out_a) !== v) @(posedge aclk);
    t = cyc;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    int t0, t1, t2, t3;
    logic [31:0] v, c1, c2;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl reset", TCC_CTRL_OFF, 32'h0);
    rc("outctl reset", TCC_OCTL_OFF, 32'h0);
    rd(8'h1C, RESP_SLVERR, v);
    chk("unmapped data", 32'h0, v);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(TCC_CNT_OFF, 32'h55, RESP_OKAY);
    rc("count read only", TCC_CNT_OFF, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(TCC_OCTL_OFF, {28'h0, i[0], 1'b0, i[0], 1'b0}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("disabled a", !i[0], pulse_out_a);
      chk("disabled b", !i[0], pulse_out_b);
    end
    wr(TCC_OCTL_OFF, 32'h5, RESP_OKAY);
    wr(TCC_WCMP_OFF, 32'h3, RESP_OKAY);
    wr(TCC_PCMP_OFF, 32'h7, RESP_OKAY);
    wr(TCC_CTRL_OFF, 32'h9, RESP_OKAY);
    wp(0, 0, t0);
    wp(0, 1, t0);
    wp(0, 0, t1);
    wp(0, 1, t2);
    chk("ppg width", 24, t1 - t0);
    chk("ppg period", 64, t2 - t0);
    wp(0, 0, t1);
    wr(TCC_WCMP_OFF, 32'h5, RESP_OKAY);
    wp(0, 1, t2);
    chk("single toggle", 40, t2 - t1);
    wp(0, 0, t3);
    chk("new width", 40, t3 - t2);
    wp(1, 0, t0);
    wp(1, 1, t0);
    wp(1, 0, t1);
    wp(1, 1, t1);
    chk("match interval", 64, t1 - t0);
    wp(0, 1, t0);
    repeat (20) @(posedge aclk);
    wr(TCC_WCMP_OFF, 32'h1, RESP_OKAY);
    wp(0, 0, t1);
    chk("full duty", 72, t1 - t0);
    wr(TCC_CTRL_OFF, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("stop level", 1, pulse_out_a);
    rc("match flags", TCC_STAT_OFF, 32'h3);
    wr(TCC_STAT_OFF, 32'hF, RESP_OKAY);
    rc("flags cleared", TCC_STAT_OFF, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(TCC_CTRL_OFF, 32'h0, RESP_OKAY);
      wr(TCC_WCMP_OFF, i ? 32'h2 : 32'h6, RESP_OKAY);
      wr(TCC_PCMP_OFF, 32'h7, RESP_OKAY);
      wr(TCC_CTRL_OFF, 32'h9, RESP_OKAY);
      wp(0, 0, t0);
      wp(0, 1, t0);
      repeat (36) @(posedge aclk);
      // period lowered below the count: count 5, width match at 6 or already at 2
      wr(TCC_PCMP_OFF, i ? 32'h3 : 32'h2, RESP_OKAY);
      wp(0, 0, t1);
      wp(0, 1, t2);
      chk("stretched period", 2048, t2 - t0);
      if (i == 0) chk("width kept", 48, t1 - t0);
    end
    wp(0, 0, t1);
    wp(0, 1, t3);
    chk("resumed period", 32, t3 - t2);
    wr(TCC_WCMP_OFF, 32'h1, RESP_OKAY);
    wr(TCC_PCMP_OFF, 32'h1, RESP_OKAY);
    for (int s = 0; s < 9; s++) begin
      wr(TCC_CTRL_OFF, 32'h0, RESP_OKAY);
      wr(TCC_CTRL_OFF, 32'h9 | (s << 8), RESP_OKAY);
      wp(0, 0, t0);
      wp(0, 1, t0);
      wp(0, 0, t1);
      wp(0, 1, t1);
      chk("prescaled period", 16 << s, t1 - t0);
    end
    for (int i = 0; i < 2; i++) begin
      wr(TCC_CTRL_OFF, 32'h0, RESP_OKAY);
      wr(TCC_WCMP_OFF, i ? 32'hFF : 32'h1, RESP_OKAY);
      wr(TCC_CTRL_OFF, 32'h1, RESP_OKAY);
      wp(0, 0, t0);
      wp(0, 1, t0);
      wp(0, 0, t1);
      wp(0, 1, t2);
      chk("pwm width", i ? 2040 : 8, t1 - t0);
      chk("pwm period", 2048, t2 - t0);
    end
    wr(TCC_CTRL_OFF, 32'h0, RESP_OKAY);
    wr(TCC_CTRL_OFF, 32'h5, RESP_OKAY);
    src.cap_set(1'b1);
    t0 = cyc;
    repeat (20) @(posedge aclk);
    rd(TCC_CAP_OFF, RESP_OKAY, c1);
    while (cyc != t0 + 79) @(posedge aclk);
    src.cap_set(1'b0);
    repeat (20) @(posedge aclk);
    rd(TCC_CAP_OFF, RESP_OKAY, c2);
    chk("capture delta", 10, c2 - c1);
    src.cap_set(1'b1);
    @(posedge aclk);
    src.cap_set(1'b0);
    repeat (20) @(posedge aclk);
    rc("glitch ignored", TCC_CAP_OFF, c2);
    wr(TCC_CTRL_OFF, 32'h0, RESP_OKAY);
    wr(TCC_CTRL_OFF, 32'h3, RESP_OKAY);
    repeat (5) src.evt_pulse(8, 8);
    repeat (10) @(posedge aclk);
    rc("event count", TCC_CNT_OFF, 32'h4);
    summarize();
  end
endmodule

bind tcc_top tcc_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_out_a,
  .pulse_out_b);
